// file: core/asptmr_pkg.sv
// package: register map, field layout and constants of the serial port
// ----------------------------------------------------------------------
// ----------------------------------------------------------------------
package asptmr_pkg;
   // byte addresses of the APB registers
   localparam logic [7:0] ADDR_CONTROL = 8'h00;
   localparam logic [7:0] ADDR_DATA = 8'h04;
   localparam logic [7:0] ADDR_TIMER = 8'h08;
   // control register bit positions
   localparam int BIT_RX_DONE = 0;
   localparam int BIT_TX_DONE = 1;
   localparam int BIT_NINTH_RX = 2;
   localparam int BIT_NINTH_TX = 3;
   localparam int BIT_RX_EN = 4;
   localparam int BIT_MULTIPROC = 5;
   localparam int BIT_UNUSED = 6;
   localparam int BIT_FORMAT = 7;
   // timer register bit positions
   localparam int BIT_TMR_RUN = 16;
   localparam int BIT_IRQ_EN = 17;
   // reset values
   localparam logic [7:0] RESET_CONTROL = 8'h40;
   localparam logic [7:0] RESET_DATA = 8'h00;
   localparam logic [7:0] RESET_RELOAD = 8'h00;
   // timing: overflows per bit, rx samples at mid bit
   localparam logic [1:0] OVF_PER_BIT = 2'h2;
   localparam logic [3:0] BITS_8 = 4'h9;
   localparam logic [3:0] BITS_9 = 4'ha;
   // control fields gathered for transfer between processes
   typedef struct packed {
      logic format;
      logic multiproc;
      logic rx_en;
      logic ninth_tx;
   } asptmr_cfg_t;
   typedef enum logic [1:0] {TX_IDLE, TX_START, TX_SHIFT, TX_STOP} asptmr_txs_t;
   typedef enum logic [1:0] {RX_IDLE, RX_START, RX_SHIFT, RX_STOP} asptmr_rxs_t;
endpackage // asptmr_pkg

// file: core/asptmr_top.sv
// serial port with baud timer, APB register slave
`timescale 1ns/10ps
module asptmr_top
(
   // apb clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // serial line and event
   input wire logic serial_rx_pin,
   output logic serial_tx_pin,
   output logic irq
);
   import asptmr_pkg::*;

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   asptmr_cfg_t cfg;
   logic tx_done_flag;
   logic rx_done_flag;
   logic ninth_rx_bit;
   logic [7:0] serial_data_buffer;
   logic [7:0] tx_shift;
   logic [7:0] baud_timer_reload_byte;
   logic [7:0] baud_timer_low_byte;
   logic [7:0] rx_timer;
   logic timer_run;
   logic irq_en;
   logic wr;
   logic rd;
   logic tx_start_req;
   logic tx_set_done;
   logic rx_set_done;
   logic rx_ovf;
   logic tx_ovf;
   logic rx_restart;
   logic rx_prev;

   assign wr = psel && penable && pwrite;
   assign rd = psel && !penable && !pwrite;
   assign tx_start_req = wr && paddr == ADDR_DATA;

   // overflow detection shared by both counters
   function automatic logic ovf(input logic [7:0] cnt);
      return cnt == 8'hff;
   endfunction

   // ----------------------------------------------------------------
   // apb slave: zero wait state, unmapped reads zero, no error
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0;
      end
      else
      begin
         pready <= psel && !penable;
         pslverr <= 1'b0;
         if (rd)
         begin
            prdata <= 32'h0;
            unique case (paddr)
               ADDR_CONTROL:
               begin
                  prdata[BIT_FORMAT] <= cfg.format;
                  prdata[BIT_UNUSED] <= 1'b1;
                  prdata[BIT_MULTIPROC] <= cfg.multiproc;
                  prdata[BIT_RX_EN] <= cfg.rx_en;
                  prdata[BIT_NINTH_TX] <= cfg.ninth_tx;
                  prdata[BIT_NINTH_RX] <= ninth_rx_bit;
                  prdata[BIT_TX_DONE] <= tx_done_flag;
                  prdata[BIT_RX_DONE] <= rx_done_flag;
               end
               ADDR_DATA: prdata[7:0] <= serial_data_buffer;
               ADDR_TIMER:
               begin
                  prdata[7:0] <= baud_timer_low_byte;
                  prdata[15:8] <= baud_timer_reload_byte;
                  prdata[BIT_TMR_RUN] <= timer_run;
                  prdata[BIT_IRQ_EN] <= irq_en;
               end
               default: prdata <= 32'h0;
            endcase
         end
      end

   // the access phase only completes once pready is high, so writes
   // are taken in the access cycle where pready stands
   logic wr_take;
   assign wr_take = wr && pready;

   // control bits written by software
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         cfg <= '0;
         baud_timer_reload_byte <= RESET_RELOAD;
         timer_run <= 1'b0;
         irq_en <= 1'b0;
      end
      else if (wr_take && paddr == ADDR_CONTROL)
      begin
         cfg.format <= pwdata[BIT_FORMAT];
         cfg.multiproc <= pwdata[BIT_MULTIPROC];
         cfg.rx_en <= pwdata[BIT_RX_EN];
         cfg.ninth_tx <= pwdata[BIT_NINTH_TX];
      end
      else if (wr_take && paddr == ADDR_TIMER)
      begin
         baud_timer_reload_byte <= pwdata[15:8];
         timer_run <= pwdata[BIT_TMR_RUN];
         irq_en <= pwdata[BIT_IRQ_EN];
      end

   // done flags: hardware set beats a software clear in the same cycle
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         tx_done_flag <= 1'b0;
         rx_done_flag <= 1'b0;
      end
      else
      begin
         if (tx_set_done)
            tx_done_flag <= 1'b1;
         else if (wr_take && paddr == ADDR_CONTROL)
            tx_done_flag <= pwdata[BIT_TX_DONE];
         if (rx_set_done)
            rx_done_flag <= 1'b1;
         else if (wr_take && paddr == ADDR_CONTROL)
            rx_done_flag <= pwdata[BIT_RX_DONE];
      end

   // interrupt follows the flags, never clears them
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         irq <= 1'b0;
      else
         irq <= irq_en && (tx_done_flag || rx_done_flag);

   // ----------------------------------------------------------------
   // baud timers: the tx counter is visible, the rx copy hidden
   // ----------------------------------------------------------------
   assign tx_ovf = timer_run && ovf(baud_timer_low_byte);
   assign rx_ovf = timer_run && ovf(rx_timer);

   // timer ticks on pclk; prescaling is outside this block
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         baud_timer_low_byte <= RESET_RELOAD;
      else if (wr_take && paddr == ADDR_TIMER)
         baud_timer_low_byte <= pwdata[7:0];
      else if (tx_ovf)
         baud_timer_low_byte <= baud_timer_reload_byte;
      else if (timer_run)
         baud_timer_low_byte <= baud_timer_low_byte + 8'h01;

   // rx copy; a start edge reloads it so bit phase follows the line
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         rx_timer <= RESET_RELOAD;
      else if (rx_restart || rx_ovf)
         rx_timer <= baud_timer_reload_byte;
      else if (timer_run)
         rx_timer <= rx_timer + 8'h01;

   // ----------------------------------------------------------------
   // transmitter
   // ----------------------------------------------------------------
   asptmr_txs_t tx_state;
   logic tx_half;
   logic [3:0] tx_cnt;
   logic tx_ninth;

   // one bit lasts two overflows of the tx counter
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         tx_state <= TX_IDLE;
         tx_half <= 1'b0;
         tx_cnt <= 4'h0;
         tx_shift <= RESET_DATA;
         tx_ninth <= 1'b0;
         serial_tx_pin <= 1'b1;
      end
      else if (tx_start_req)
      begin
         tx_shift <= pwdata[7:0];
         tx_ninth <= cfg.ninth_tx;
         tx_state <= TX_START;
         tx_half <= 1'b0;
         tx_cnt <= cfg.format ? BITS_9 : BITS_8;
         serial_tx_pin <= 1'b1;
      end
      else if (tx_ovf)
      begin
         tx_half <= !tx_half;
         if (tx_half)
         begin
            unique case (tx_state)
               TX_IDLE: serial_tx_pin <= 1'b1;
               TX_START:
               begin
                  serial_tx_pin <= 1'b0;
                  tx_state <= TX_SHIFT;
               end
               TX_SHIFT:
               begin
                  if (tx_cnt == 4'h1)
                  begin
                     serial_tx_pin <= 1'b1;
                     tx_state <= TX_STOP;
                  end
                  else
                  begin
                     serial_tx_pin <= tx_shift[0];
                     tx_shift <= {tx_ninth, tx_shift[7:1]};
                  end
                  tx_cnt <= tx_cnt - 4'h1;
               end
               TX_STOP:
               begin
                  serial_tx_pin <= 1'b1;
                  tx_state <= TX_IDLE;
               end
            endcase
         end
      end

   assign tx_set_done = tx_ovf && tx_half && tx_state == TX_SHIFT
                        && tx_cnt == 4'h1;

   // ----------------------------------------------------------------
   // receiver: samples at mid bit, two rx overflows per bit
   // ----------------------------------------------------------------
   asptmr_rxs_t rx_state;
   logic rx_half;
   logic [3:0] rx_cnt;
   logic [8:0] rx_shift;
   logic rx_accept;

   // sampling at the first overflow after the reload lands mid bit
   assign rx_restart = rx_state == RX_IDLE && cfg.rx_en && timer_run
                       && rx_prev && !serial_rx_pin;

   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         rx_prev <= 1'b1;
      else
         rx_prev <= serial_rx_pin;

   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         rx_state <= RX_IDLE;
         rx_half <= 1'b0;
         rx_cnt <= 4'h0;
         rx_shift <= 9'h000;
      end
      else if (rx_restart)
      begin
         rx_state <= RX_START;
         rx_half <= 1'b0;
         rx_cnt <= cfg.format ? BITS_9 : BITS_8;
      end
      else if (rx_ovf && rx_state != RX_IDLE)
      begin
         rx_half <= !rx_half;
         if (!rx_half)
         begin
            unique case (rx_state)
               RX_IDLE: rx_state <= RX_IDLE;
               RX_START: rx_state <= serial_rx_pin ? RX_IDLE : RX_SHIFT;
               RX_SHIFT:
               begin
                  rx_shift <= {serial_rx_pin, rx_shift[8:1]};
                  rx_cnt <= rx_cnt - 4'h1;
                  if (rx_cnt == 4'h2)
                     rx_state <= RX_STOP;
               end
               RX_STOP: rx_state <= RX_IDLE;
            endcase
         end
      end

   // stop sample: in 8-bit the stop level is the ninth; in 9-bit ignored
   logic rx_ninth;
   logic [7:0] rx_byte;
   assign rx_ninth = cfg.format ? rx_shift[8] : serial_rx_pin;
   assign rx_byte = cfg.format ? rx_shift[7:0] : rx_shift[8:1];
   assign rx_accept = rx_ovf && !rx_half && rx_state == RX_STOP
                      && !rx_done_flag
                      && (!cfg.multiproc || rx_ninth);
   assign rx_set_done = rx_accept;

   // one-byte holding buffer; a frame that fails acceptance or overruns
   // is dropped so the first byte survives
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         serial_data_buffer <= RESET_DATA;
         ninth_rx_bit <= 1'b0;
      end
      else if (rx_accept)
      begin
         serial_data_buffer <= rx_byte;
         ninth_rx_bit <= rx_ninth;
      end

endmodule // asptmr_top

// file: bench/asptmr_monitor.sv
// checker: port-level properties of the serial port
`timescale 1ns/10ps
module asptmr_chk
(
   // apb side
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // serial line and event
   input wire logic serial_rx_pin,
   input wire logic serial_tx_pin,
   input wire logic irq
);
   import asptmr_pkg::*;
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   // register access: no wait state, ready in the first access cycle
   a_zero_wait: assert property (psel && !penable |=> pready)
      else $error("ready not in first access cycle");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("ready held too long");
   a_ready_access: assert property (pready |-> psel && penable)
      else $error("ready outside access");
   a_no_error: assert property (!pslverr)
      else $error("error response seen");
   a_ctl_read: assert property (pready && !pwrite &&
      paddr == ADDR_CONTROL |-> prdata[BIT_UNUSED] && prdata[31:8] == 0)
      else $error("control read bad");
   a_hole_zero: assert property (pready && !pwrite &&
      paddr == 8'h0c |-> prdata == 32'h0) else $error("unmapped read");
   // flags only drop after a software write, irq lags the flag by one
   a_irq_hold: assert property ($fell(irq) |->
      $past(pready && pwrite, 2)) else $error("irq fell alone");
   // bench runs 8-cycle bits, so any low run on the line lasts at least 8
   a_low_len: assert property ($fell(serial_tx_pin) |->
      !serial_tx_pin [*8]) else $error("short low bit");
   a_tx_idle: assert property ($rose(presetn) |->
      serial_tx_pin [*2]) else $error("line not idle high");
   // main scenarios
   cover property ($rose(irq));
   cover property ($fell(serial_tx_pin));
   cover property (pready && !pwrite && paddr == ADDR_DATA);
endmodule // asptmr_chk

// file: bench/asptmr_remote.sv
// remote serial node: sends frames to the port and decodes its output
`timescale 1ns/10ps
module asptmr_remote
#(
   parameter int BIT_CYC = 8
)
(
   // clock and line pins
   input wire logic clk,
   input wire logic line_in,
   output logic line_out
);
   logic [9:0] rx_q[$];
   logic [9:0] shift;
   int rx_bits = 9;
   initial line_out = 1'b1;
   // one frame, lsb first; in 8-bit frames the eleventh slot is idle
   task automatic send(input logic [7:0] d, input logic nine,
      input logic use_nine, input logic stop_v);
      logic [10:0] f;
      f = use_nine ? {stop_v, nine, d, 1'b0} : {1'b1, stop_v, d, 1'b0};
      for (int i = 0; i < 11; i++)
      begin
         @(posedge clk);
         line_out <= f[i];
         repeat (BIT_CYC - 1) @(posedge clk);
      end
      @(posedge clk);
      line_out <= 1'b1;
   endtask
   // decoder: falling edge opens a frame, sample each bit at mid bit
   always
   begin
      @(negedge line_in);
      shift = '0;
      repeat (BIT_CYC / 2) @(posedge clk);
      for (int i = 0; i < rx_bits; i++)
      begin
         repeat (BIT_CYC) @(posedge clk);
         shift[i] = line_in;
      end
      rx_q.push_back(shift);
   end
endmodule // asptmr_remote

// file: bench/tb_top.sv
// top of the bench: apb master, reference model and remote node
`timescale 1ns/10ps
module tb_top;
   import asptmr_pkg::*;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic serial_rx_pin;
   logic serial_tx_pin;
   logic irq;
   int num_errors = 0;
   int n_tests = 0;
   int n;
   logic [31:0] rd;
   logic [9:0] fr;
   logic [7:0] b;
   logic f, mp, bv, nt;
   // reference model of the receive side
   logic [7:0] m_rxbuf = 8'h00;
   logic m_ninth = 1'b0;
   logic m_rxd = 1'b0;
   always #25 pclk = ~pclk;
   asptmr_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .serial_rx_pin(serial_rx_pin), .serial_tx_pin(serial_tx_pin),
      .irq(irq));
   asptmr_remote #(.BIT_CYC(8)) i_rem (.clk(pclk),
      .line_in(serial_tx_pin), .line_out(serial_rx_pin));
   task automatic chk(input string name, input logic [31:0] seen,
      input logic [31:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // apb transfer; ends with an idle cycle so psel is never set twice
   task automatic apb(input logic wr, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] q);
      int k;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do
      begin
         @(posedge pclk);
         k++;
      end
      while (pready !== 1'b1 && k < 20);
      if (k >= 20)
      begin
         num_errors++;
         summarize();
      end
      q = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   initial
   begin
      void'($urandom(32'h55d83467));
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, ADDR_CONTROL, 32'h0, rd);
      chk("control", rd, {24'h0, RESET_CONTROL});
      apb(1'b0, ADDR_DATA, 32'h0, rd);
      chk("data", rd, {24'h0, RESET_DATA});
      apb(1'b1, 8'h0c, 32'hffffffff, rd);
      apb(1'b0, 8'h0c, 32'h0, rd);
      chk("unmapped", rd, 32'h0);
      // run, irq on, reload fc: overflow every 4 cycles, 8-cycle bits
      apb(1'b1, ADDR_TIMER, 32'h0003fcfc, rd);
      apb(1'b0, ADDR_TIMER, 32'h0, rd);
      chk("timer", {rd[31:8], 8'h00}, 32'h0003fc00);
      $display("test registers done");
      for (int k = 0; k < 4; k++)
      begin
         f = k[0];
         nt = k[1];
         b = 8'($urandom);
         i_rem.rx_bits = f ? 10 : 9;
         apb(1'b1, ADDR_CONTROL, {24'h0, f, 3'b000, nt, 3'b000}, rd);
         apb(1'b1, ADDR_DATA, {24'h0, b}, rd);
         n = 0;
         while (i_rem.rx_q.size() == 0 && n < 3000)
         begin
            @(posedge pclk);
            n++;
         end
         if (n >= 3000)
         begin
            num_errors++;
            summarize();
         end
         fr = i_rem.rx_q.pop_front();
         chk("frame", 32'(fr), 32'(f ? {1'b1, nt, b} : {2'b01, b}));
         apb(1'b0, ADDR_CONTROL, 32'h0, rd);
         chk("tx done", 32'(rd[1:0]), 32'h2);
         chk("irq", 32'(irq), 32'h1);
         apb(1'b1, ADDR_CONTROL, {24'h0, f, 3'b000, nt, 3'b000}, rd);
         repeat (3) @(posedge pclk);
         chk("irq clear", 32'(irq), 32'h0);
      end
      $display("test transmit done");
      // receive: all formats and checks, overrun, then receiver off
      for (int i = 0; i < 9; i++)
      begin
         f = i[2];
         mp = i[1];
         bv = i[0];
         b = 8'($urandom);
         apb(1'b1, ADDR_CONTROL,
            {24'h0, f, 1'b0, mp, (i < 8), 3'b000, m_rxd}, rd);
         repeat ($urandom % 8) @(posedge pclk);
         i_rem.send(b, bv, f, f ? !bv : bv);
         if (i < 8 && !m_rxd && (!mp || bv))
         begin
            m_rxbuf = b;
            m_ninth = bv;
            m_rxd = 1'b1;
         end
         repeat (4) @(posedge pclk);
         apb(1'b0, ADDR_CONTROL, 32'h0, rd);
         chk("rx flags", 32'(rd[2:0]), 32'({m_ninth, 1'b0, m_rxd}));
         chk("rx irq", 32'(irq), 32'(m_rxd));
         apb(1'b0, ADDR_DATA, 32'h0, rd);
         chk("rx data", rd, {24'h0, m_rxbuf});
         if (bv)
            m_rxd = 1'b0;
      end
      $display("test receive done");
      summarize();
   end
endmodule // tb_top
bind asptmr_top asptmr_chk i_chk (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .serial_rx_pin(serial_rx_pin), .serial_tx_pin(serial_tx_pin),
   .irq(irq));
